// file: hdl/timer_compare_capture_regs.sv
// Compare and capture registers of timers one and three with shared high-byte latch
// How it works
// - Each capture event copies the timer's running count into its capture value.
// - Timer one may take the comparator output instead of its pin as capture source.
// - Each capture value is offered as the counter TOP limit when the mode asks.
// - Capture values are 16 bits and byte accesses pass through an 8-bit high latch.
// - One high-byte latch is shared by all 16-bit registers of the block.
// - Low I/O registers sit at their offset plus 0x20 in data space.
// - Timer one capture bytes decode at 0x46 and 0x47, the mask register at 0x57.
// - Timer three compare A, B, C are read-write 16-bit values reset to zero.
// - The interrupt mask register holds enables of several timers and resets to zero.
// - A write to the counter blocks compare matches on the next timer clock.
// - A match flag sets the timer clock after count equals compare; force does not.
// - A capture flag sets on capture and clears on vector or on a written one.
`timescale 1ns/100ps
module timer_compare_capture_regs
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Processor data-space access
  input wire bus_req_s bus_req,
  output logic [DATA_W-1:0] rdata,
  // Timer one and three inputs
  input wire timer_in_s t1_in,
  input wire timer_in_s t3_in,
  input wire logic timer_tick,
  input wire logic forced_compare_strobe,
  // Values to the counter logic
  output logic [VAL_W-1:0] t1_top_value,
  output logic [VAL_W-1:0] t3_top_value,
  output logic [VAL_W-1:0] t1_compare_c_value,
  output logic [VAL_W-1:0] t3_compare_a_value,
  output logic [VAL_W-1:0] t3_compare_b_value,
  output logic [VAL_W-1:0] t3_compare_c_value,
  output logic [DATA_W-1:0] timer_irq_enable_mask,
  // Flags
  output logic t1_capture_flag,
  output logic t3_capture_flag,
  output logic [3:0] match_flags
);

  logic [VAL_W-1:0] val_q [NVAL];
  logic [VAL_W-1:0] val_d [NVAL];
  logic [DATA_W-1:0] latch_q, latch_d;
  logic [DATA_W-1:0] mask_q, mask_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic cf1_q, cf1_d, cf3_q, cf3_d;
  logic [3:0] mf_q, mf_d;
  logic [3:0] match_now_q, match_now_d;
  logic blk1_q, blk1_d, blk3_q, blk3_d;
  logic [VAL_W-1:0] t1_top_q, t1_top_d, t3_top_q, t3_top_d;
  logic cap1, cap3;
  logic is_lo, is_hi;
  int sel;

  // Capture source selection and edge detection
  cap_edge u_edge1 (
    .clk(clk),
    .reset(reset),
    .src(t1_in.cap_use_comp ? t1_in.comp_out : t1_in.cap_pin),
    .event_p(cap1)
  );
  cap_edge u_edge3 (
    .clk(clk),
    .reset(reset),
    .src(t3_in.cap_pin),
    .event_p(cap3)
  );

  // Address decode: data-space address to a 16-bit value index and byte half
  always_comb begin
    sel = NVAL;
    is_lo = 1'b0;
    is_hi = 1'b0;
    unique case (bus_req.addr)
      OFS_T1_CAP_LO + IO_SHIFT: begin sel = IDX_T1_CAP; is_lo = 1'b1; end
      OFS_T1_CAP_HI + IO_SHIFT: begin sel = IDX_T1_CAP; is_hi = 1'b1; end
      OFS_T1_CMPC_LO: begin sel = IDX_T1_CMPC; is_lo = 1'b1; end
      OFS_T1_CMPC_HI: begin sel = IDX_T1_CMPC; is_hi = 1'b1; end
      OFS_T3_CAP_LO: begin sel = IDX_T3_CAP; is_lo = 1'b1; end
      OFS_T3_CAP_HI: begin sel = IDX_T3_CAP; is_hi = 1'b1; end
      OFS_T3_CMPC_LO: begin sel = IDX_T3_CMPC; is_lo = 1'b1; end
      OFS_T3_CMPC_HI: begin sel = IDX_T3_CMPC; is_hi = 1'b1; end
      OFS_T3_CMPB_LO: begin sel = IDX_T3_CMPB; is_lo = 1'b1; end
      OFS_T3_CMPB_HI: begin sel = IDX_T3_CMPB; is_hi = 1'b1; end
      OFS_T3_CMPA_LO: begin sel = IDX_T3_CMPA; is_lo = 1'b1; end
      OFS_T3_CMPA_HI: begin sel = IDX_T3_CMPA; is_hi = 1'b1; end
      default: begin sel = NVAL; end
    endcase
  end

  // Register file, shared latch and read data
  always_comb begin
    for (int i = 0; i < NVAL; i++) begin
      val_d[i] = val_q[i];
    end
    latch_d = latch_q;
    mask_d = mask_q;
    rdata_d = RST_BYTE;
    if (cap1) begin
      val_d[IDX_T1_CAP] = t1_in.count;
    end
    if (cap3) begin
      val_d[IDX_T3_CAP] = t3_in.count;
    end
    if (bus_req.rd && sel < NVAL) begin
      if (is_lo) begin
        rdata_d = val_q[sel][DATA_W-1:0];
        latch_d = val_q[sel][VAL_W-1:DATA_W];
      end else begin
        rdata_d = latch_q;
      end
    end else if (bus_req.rd && bus_req.addr == OFS_IRQ_MASK + IO_SHIFT) begin
      rdata_d = mask_q;
    end else if (bus_req.rd && bus_req.addr == OFS_T1_FLAGS + IO_SHIFT) begin
      rdata_d = RST_BYTE | (DATA_W'(cf1_q) << CAP_FLAG_BIT);
    end else if (bus_req.rd && bus_req.addr == OFS_T3_FLAGS) begin
      rdata_d = RST_BYTE | (DATA_W'(cf3_q) << CAP_FLAG_BIT);
    end
    if (bus_req.wr && sel < NVAL) begin
      if (is_hi) begin
        latch_d = bus_req.wdata;
      end else begin
        val_d[sel] = {latch_q, bus_req.wdata};
      end
    end
    if (bus_req.wr && bus_req.addr == OFS_IRQ_MASK + IO_SHIFT) begin
      mask_d = bus_req.wdata;
    end
    t1_top_d = t1_in.top_is_capture ? val_d[IDX_T1_CAP] : RST_WORD;
    t3_top_d = t3_in.top_is_capture ? val_d[IDX_T3_CAP] : RST_WORD;
  end

  // Capture flags: set wins over clear
  always_comb begin
    cf1_d = cf1_q;
    cf3_d = cf3_q;
    if (t1_in.vector_ack || (bus_req.wr && bus_req.addr == OFS_T1_FLAGS + IO_SHIFT
        && bus_req.wdata[CAP_FLAG_BIT])) begin
      cf1_d = 1'b0;
    end
    if (t3_in.vector_ack || (bus_req.wr && bus_req.addr == OFS_T3_FLAGS
        && bus_req.wdata[CAP_FLAG_BIT])) begin
      cf3_d = 1'b0;
    end
    if (cap1) begin
      cf1_d = 1'b1;
    end
    if (cap3) begin
      cf3_d = 1'b1;
    end
  end

  // Compare match: detect equality on a tick, flag on the next tick
  always_comb begin
    mf_d = mf_q;
    match_now_d = match_now_q;
    blk1_d = blk1_q | t1_in.count_written;
    blk3_d = blk3_q | t3_in.count_written;
    if (timer_tick) begin
      mf_d = mf_q | match_now_q;
      match_now_d[0] = (t1_in.count == val_q[IDX_T1_CMPC]) & ~blk1_q;
      match_now_d[1] = (t3_in.count == val_q[IDX_T3_CMPA]) & ~blk3_q;
      match_now_d[2] = (t3_in.count == val_q[IDX_T3_CMPB]) & ~blk3_q;
      match_now_d[3] = (t3_in.count == val_q[IDX_T3_CMPC]) & ~blk3_q;
      blk1_d = t1_in.count_written;
      blk3_d = t3_in.count_written;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NVAL; i++) begin
        val_q[i] <= RST_WORD;
      end
      latch_q <= RST_BYTE;
      mask_q <= RST_BYTE;
      rdata_q <= RST_BYTE;
      cf1_q <= 1'b0;
      cf3_q <= 1'b0;
      mf_q <= '0;
      match_now_q <= '0;
      blk1_q <= 1'b0;
      blk3_q <= 1'b0;
      t1_top_q <= RST_WORD;
      t3_top_q <= RST_WORD;
    end else begin
      for (int i = 0; i < NVAL; i++) begin
        val_q[i] <= val_d[i];
      end
      latch_q <= latch_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      cf1_q <= cf1_d;
      cf3_q <= cf3_d;
      mf_q <= mf_d;
      match_now_q <= match_now_d;
      blk1_q <= blk1_d;
      blk3_q <= blk3_d;
      t1_top_q <= t1_top_d;
      t3_top_q <= t3_top_d;
    end
  end

  assign rdata = rdata_q;
  assign t1_top_value = t1_top_q;
  assign t3_top_value = t3_top_q;
  assign t1_compare_c_value = val_q[IDX_T1_CMPC];
  assign t3_compare_a_value = val_q[IDX_T3_CMPA];
  assign t3_compare_b_value = val_q[IDX_T3_CMPB];
  assign t3_compare_c_value = val_q[IDX_T3_CMPC];
  assign timer_irq_enable_mask = mask_q;
  assign t1_capture_flag = cf1_q;
  assign t3_capture_flag = cf3_q;
  assign match_flags = mf_q;

  // Checks
  capture_copy_a: assert property (@(posedge clk) disable iff (reset)
    cap1 |=> val_q[IDX_T1_CAP] == $past(t1_in.count))
    else $error("capture value not loaded");
  capture_flag_a: assert property (@(posedge clk) disable iff (reset)
    cap3 |=> t3_capture_flag)
    else $error("capture flag not set");
  low_read_latch_a: assert property (@(posedge clk) disable iff (reset)
    (bus_req.rd && is_lo && !(bus_req.wr && is_hi)) |=> latch_q == $past(val_q[sel][VAL_W-1:DATA_W]))
    else $error("latch not loaded on low read");
  mask_reset_a: assert property (@(posedge clk) $rose(!reset) |-> mask_q == RST_BYTE)
    else $error("mask not reset");
  write_block_a: assert property (@(posedge clk) disable iff (reset)
    (timer_tick && blk3_q) |=> !match_now_q[1])
    else $error("match not blocked");
  match_delay_a: assert property (@(posedge clk) disable iff (reset)
    (timer_tick && match_now_q[0]) |=> mf_q[0])
    else $error("match flag late");
  top_follow_a: assert property (@(posedge clk) disable iff (reset)
    t1_in.top_is_capture |=> t1_top_value == val_q[IDX_T1_CAP])
    else $error("top value wrong");
  cmp_write_a: assert property (@(posedge clk) disable iff (reset)
    (bus_req.wr && bus_req.addr == OFS_T3_CMPA_LO) |=>
      t3_compare_a_value == {$past(latch_q), $past(bus_req.wdata)})
    else $error("compare write wrong");
  // The forced strobe only acts on the waveform outside, never on the match flags
  force_no_flag_a: assert property (@(posedge clk) disable iff (reset)
    (forced_compare_strobe && !timer_tick) |=> mf_q == $past(mf_q))
    else $error("forced strobe changed a match flag");
  capture_c: cover property (@(posedge clk) cap1);
  match_c: cover property (@(posedge clk) mf_q[1]);
  word_write_c: cover property (@(posedge clk) bus_req.wr && is_hi ##1 bus_req.wr && is_lo);
endmodule

// file: hdl/tcc_pkg.sv
// Package: register map, field layouts and carriers for the compare/capture register block
package tcc_pkg;

  localparam int DATA_W = 8;
  localparam int VAL_W = 16;
  localparam int ADDR_W = 8;

  // Low I/O space: printed offsets plus the data-space shift
  localparam logic [ADDR_W-1:0] IO_SHIFT = 8'h20;
  localparam logic [ADDR_W-1:0] IO_LAST = 8'h3F;
  localparam logic [ADDR_W-1:0] EXT_FIRST = 8'h60;

  localparam logic [ADDR_W-1:0] OFS_T1_CAP_LO = 8'h26;
  localparam logic [ADDR_W-1:0] OFS_T1_CAP_HI = 8'h27;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h37;
  localparam logic [ADDR_W-1:0] OFS_T1_CMPC_LO = 8'h78;
  localparam logic [ADDR_W-1:0] OFS_T1_CMPC_HI = 8'h79;
  localparam logic [ADDR_W-1:0] OFS_T3_CAP_LO = 8'h80;
  localparam logic [ADDR_W-1:0] OFS_T3_CAP_HI = 8'h81;
  localparam logic [ADDR_W-1:0] OFS_T3_CMPC_LO = 8'h82;
  localparam logic [ADDR_W-1:0] OFS_T3_CMPC_HI = 8'h83;
  localparam logic [ADDR_W-1:0] OFS_T3_CMPB_LO = 8'h84;
  localparam logic [ADDR_W-1:0] OFS_T3_CMPB_HI = 8'h85;
  localparam logic [ADDR_W-1:0] OFS_T3_CMPA_LO = 8'h86;
  localparam logic [ADDR_W-1:0] OFS_T3_CMPA_HI = 8'h87;
  // Capture flag register (t1 in the low file, t3 in the extended file)
  localparam logic [ADDR_W-1:0] OFS_T1_FLAGS = 8'h36;
  localparam logic [ADDR_W-1:0] OFS_T3_FLAGS = 8'h7C;

  localparam int CAP_FLAG_BIT = 5;
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [VAL_W-1:0] RST_WORD = 16'h0000;

  // Index of each 16-bit value held here
  localparam int NREG = 5;
  localparam int IDX_T1_CAP = 0;
  localparam int IDX_T1_CMPC = 1;
  localparam int IDX_T3_CAP = 2;
  localparam int IDX_T3_CMPC = 3;
  localparam int IDX_T3_CMPB = 4;
  localparam int IDX_T3_CMPA = 5;
  localparam int NVAL = 6;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic [VAL_W-1:0] count;
    logic count_written;
    logic cap_pin;
    logic cap_use_comp;
    logic comp_out;
    logic top_is_capture;
    logic vector_ack;
  } timer_in_s;

endpackage

// file: hdl/cap_edge.sv
// Capture event detector: rising edge of the selected source
`timescale 1ns/100ps
module cap_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Source
  input wire logic src,
  // Event
  output logic event_p
);
  logic prev_q, prev_d;

  always_comb begin
    prev_d = src;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // Track the source during reset so a high idle level gives no false edge after release
      prev_q <= src;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign event_p = src & ~prev_q;
endmodule

// file: tb/cpu_model.sv
// Processor model issuing byte reads and writes in data space
`timescale 1ns/100ps
module cpu_model
  import tcc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Data-space bus
  output bus_req_s req,
  input wire logic [DATA_W-1:0] rdata
);
  initial req = '{rd: 1'b0, wr: 1'b0, addr: 8'hFF, wdata: 8'hFF};

  // Only data-space addresses are issued, low I/O at offset plus 0x20
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1;
    d = rdata;
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask

  // Write high then low, read low then high, nothing in between
  task automatic wr16(input logic [ADDR_W-1:0] a, input logic [VAL_W-1:0] v);
    wr(a + 8'h01, v[15:8]);
    wr(a, v[7:0]);
  endtask

  task automatic rd16(input logic [ADDR_W-1:0] a, output logic [VAL_W-1:0] v);
    rd(a, v[7:0]);
    rd(a + 8'h01, v[15:8]);
  endtask
endmodule

// file: tb/tb_top.sv
// Testbench for the compare and capture register block
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import tcc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  bus_req_s bus_req;
  logic [DATA_W-1:0] rdata, irq_mask, rb;
  timer_in_s t1_in, t3_in;
  logic timer_tick = 1'b0;
  logic forced_compare_strobe = 1'b0;
  logic [VAL_W-1:0] t1_top, t3_top, v;
  logic [VAL_W-1:0] cmp [4];
  logic t1_flag, t3_flag;
  logic [3:0] match_flags;
  int fail_count = 0;
  int check_count = 0;
  typedef struct {logic [ADDR_W-1:0] lo; logic [VAL_W-1:0] val; int idx;} row_s;
  row_s rows [4] = '{'{8'h78, 16'hA55A, 0}, '{8'h86, 16'h1234, 1},
                     '{8'h84, 16'hFFFF, 2}, '{8'h82, 16'h0001, 3}};

  always #20 clk = ~clk;

  cpu_model cpu (.clk(clk), .req(bus_req), .rdata(rdata));

  timer_compare_capture_regs dut (.clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
    .t1_in(t1_in), .t3_in(t3_in), .timer_tick(timer_tick),
    .forced_compare_strobe(forced_compare_strobe), .t1_top_value(t1_top),
    .t3_top_value(t3_top), .t1_compare_c_value(cmp[0]), .t3_compare_a_value(cmp[1]),
    .t3_compare_b_value(cmp[2]), .t3_compare_c_value(cmp[3]),
    .timer_irq_enable_mask(irq_mask), .t1_capture_flag(t1_flag),
    .t3_capture_flag(t3_flag), .match_flags(match_flags));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      timer_tick = 1'b1;
      step(1);
      timer_tick = 1'b0;
      step(1);
    end
  endtask

  task automatic complete_run;
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    complete_run();
  end

  initial begin
    t1_in = '0;
    t3_in = '0;
    step(5);
    reset = 1'b0;
    `CHK(irq_mask, RST_BYTE)
    foreach (cmp[i]) `CHK(cmp[i], RST_WORD)
    cpu.rd16(8'h46, v);
    `CHK(v, RST_WORD)
    foreach (rows[i]) begin
      cpu.wr16(rows[i].lo, rows[i].val);
      `CHK(cmp[rows[i].idx], rows[i].val)
      cpu.rd16(rows[i].lo, v);
      `CHK(v, rows[i].val)
    end
    // High byte aimed at A is committed by the low write of B
    cpu.wr(8'h87, 8'hC3);
    cpu.wr(8'h84, 8'h3C);
    `CHK(cmp[2], 16'hC33C)
    `CHK(cmp[1], 16'h1234)
    cpu.wr(8'h57, 8'h5A);
    cpu.rd(8'h57, rb);
    `CHK(rb, 8'h5A)
    `CHK(irq_mask, 8'h5A)
    t1_in.count = 16'hBEEF;
    t1_in.cap_pin = 1'b1;
    step(2);
    `CHK(t1_flag, 1'b1)
    cpu.rd(8'h56, rb);
    `CHK(rb, 8'h20)
    cpu.rd16(8'h46, v);
    `CHK(v, 16'hBEEF)
    // Printed offset without the data-space shift decodes nothing
    cpu.rd(8'h26, rb);
    `CHK(rb, 8'h00)
    t1_in.top_is_capture = 1'b1;
    step(2);
    `CHK(t1_top, 16'hBEEF)
    // With the comparator selected a pin edge must not capture
    t1_in.cap_use_comp = 1'b1;
    t1_in.cap_pin = 1'b0;
    step(2);
    t1_in.count = 16'h0F0F;
    t1_in.cap_pin = 1'b1;
    step(2);
    `CHK(t1_top, 16'hBEEF)
    t1_in.comp_out = 1'b1;
    step(2);
    `CHK(t1_top, 16'h0F0F)
    t1_in.vector_ack = 1'b1;
    step(1);
    t1_in.vector_ack = 1'b0;
    step(1);
    `CHK(t1_flag, 1'b0)
    t3_in.count = 16'h4321;
    t3_in.cap_pin = 1'b1;
    step(2);
    `CHK(t3_flag, 1'b1)
    cpu.rd16(8'h80, v);
    `CHK(v, 16'h4321)
    t3_in.top_is_capture = 1'b1;
    step(2);
    `CHK(t3_top, 16'h4321)
    cpu.rd(8'h7C, rb);
    `CHK(rb, 8'h20)
    cpu.wr(8'h7C, 8'h20);
    `CHK(t3_flag, 1'b0)
    // Count equals compare A; strobe alone, then a counter write, then a real match
    t3_in.count = 16'h1234;
    forced_compare_strobe = 1'b1;
    step(1);
    forced_compare_strobe = 1'b0;
    step(2);
    `CHK(match_flags, 4'h0)
    t3_in.count_written = 1'b1;
    step(1);
    t3_in.count_written = 1'b0;
    tick(2);
    `CHK(match_flags, 4'h0)
    tick(1);
    `CHK(match_flags, 4'h2)
    // Mid-run reset with both capture sources held high: no false capture after release
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    step(2);
    `CHK(match_flags, 4'h0)
    `CHK(t1_flag, 1'b0)
    `CHK(t3_flag, 1'b0)
    `CHK(cmp[1], RST_WORD)
    `CHK(irq_mask, RST_BYTE)
    `CHK(t1_top, RST_WORD)
    `CHK(t3_top, RST_WORD)
    cpu.rd16(8'h80, v);
    `CHK(v, RST_WORD)
    complete_run();
  end
endmodule
